// ### hw/dac_mode_regs.vh
// Constants for the mode-control register bank: register numbers, field positions, reset values and counts.
// Assumes a 16-bit control frame delivered already deserialised by the serial control port.
// Overview of operation
// - Mute outputs after 1024 zero samples both channels
// - Zero mute ignored in stream mode
// - Frame bit 15: 0 write, 1 read
// - Writing reset bit emits one reset pulse
// - Mode bit selects stream or PCM input
// - Bypass bit feeds external filter to modulator
// - Mono bit runs both channels balanced
// - Channel select picks left or right
// - Rate field: 64x, 32x, 128x, 11 reserved
// - Stream mode: rate field sets bit clock
// - Stream zero field: off, balanced, pattern
// - Stream zero by 8-bit balance or 200 ms pattern
// - PCM zero flag enable, reset to one
// - PCM zero after 1024 frame or word clocks
// - Status: bit1 right flag, bit0 left flag
// - Status and ID readback only
// - ID register returns 5-bit identifier
`ifndef DAC_MODE_REGS_VH
`define DAC_MODE_REGS_VH

// =====================================================================
// Register numbers (frame bits 14..8).
`define REG_SYS_MODE        7'h14
`define REG_ZF_ENABLE       7'h15
`define REG_ZF_STATUS       7'h16
`define REG_DEV_ID          7'h17

// =====================================================================
// Frame fields.
`define FRAME_DIR_BIT       15
`define FRAME_DIR_READ      1'b1

// =====================================================================
// System mode control field positions.
`define SM_SOFT_SYSTEM_RESET_BIT         6
`define SM_STREAM_BIT       5
`define SM_BYPASS_BIT       4
`define SM_MONO_BIT         3
`define SM_MONO_CHANNEL_SELECT_BIT         2
`define SM_RATE_HI          1
`define SM_RATE_LO          0

// Modulator rate codes.
`define RATE_64X            2'h0
`define RATE_32X            2'h1
`define RATE_128X           2'h2
`define RATE_RSV            2'h3

// =====================================================================
// Zero flag enable control field positions and reset values.
`define ZE_DZ_HI            2
`define ZE_DZ_LO            1
`define ZE_PCM_ZERO_FLAG_EN_BIT         0
`define ZE_RESET            8'h01
`define SM_RESET            8'h00

// =====================================================================
// Detection counts and timing.
`define ZERO_RUN_COUNT      1024
`define STREAM_PATTERN      8'h96
`define PATTERN_TIME_MS     200
`define CLK_FREQ_HZ         20000000

`endif

// ### hw/chan_zero_detect.v
// One channel of zero detection for PCM, external-filter and 1-bit stream input.
// Assumes sample strobes and stream bytes arrive synchronous to core_clk.
`timescale 1ns/100ps
`include "dac_mode_regs.vh"

module chan_zero_detect #(
  parameter RUN_COUNT   = `ZERO_RUN_COUNT,                           // Zero samples needed.
  parameter PAT_CYCLES  = `PATTERN_TIME_MS * (`CLK_FREQ_HZ / 1000)    // Cycles of steady pattern.
) (
  input  wire        core_clk,       // System clock.
  input  wire        rst,            // Synchronous reset, active high.
  input  wire        sample_stb,     // One pulse per frame clock or word clock.
  input  wire        sample_zero,    // Sample at this strobe is zero.
  input  wire        byte_stb,       // One pulse per 8 stream bits.
  input  wire [7:0]  stream_byte,    // Last 8 stream bits.
  input  wire        stream_mode,    // 1-bit stream input active.
  input  wire [1:0]  stream_sel,     // Stream detection select.
  output reg         zero_q          // Continuous zero detected.
);

  // =====================================================================
  // Counters.
  reg [10:0] run_q;                  // Consecutive zero samples, saturating.
  reg [31:0] pat_q;                  // Cycles the pattern has held.
  reg        bal_q;                  // Last byte was balanced.
  wire [3:0] ones;                   // Ones in the current byte.

  assign ones = {3'h0, stream_byte[0]} + {3'h0, stream_byte[1]} + {3'h0, stream_byte[2]}
              + {3'h0, stream_byte[3]} + {3'h0, stream_byte[4]} + {3'h0, stream_byte[5]}
              + {3'h0, stream_byte[6]} + {3'h0, stream_byte[7]};

  // =====================================================================
  // Count zero runs and stream patterns; the flag follows the selected detector.
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      run_q  <= 11'h000;
      pat_q  <= 32'h0;
      bal_q  <= 1'b0;
      zero_q <= 1'b0;
    end
    else
    begin
      // A non-zero sample restarts the run.
      if (sample_stb)
        run_q <= !sample_zero ? 11'h000 : (run_q == RUN_COUNT[10:0]) ? run_q : run_q + 11'h001;
      // Byte balance and pattern continuity.
      if (byte_stb)
        bal_q <= (ones == 4'h4);
      if (byte_stb && stream_byte != `STREAM_PATTERN)
        pat_q <= 32'h0;
      else if (pat_q != PAT_CYCLES)
        pat_q <= pat_q + 32'h1;
      // Flag selection by input mode.
      if (!stream_mode)
        zero_q <= (run_q == RUN_COUNT[10:0]);
      else if (stream_sel == 2'h1)
        zero_q <= bal_q;
      else if (stream_sel[1])
        zero_q <= (pat_q == PAT_CYCLES);
      else
        zero_q <= 1'b0;
    end
  end

endmodule // chan_zero_detect

// ### hw/dac_mode_ctrl_zero_detect.v
// Mode-control register bank with zero detection and infinite-zero mute.
// Assumes frames arrive whole as a one-cycle strobe from the serial port, synchronous to core_clk.
`timescale 1ns/100ps
`include "dac_mode_regs.vh"

module dac_mode_ctrl_zero_detect #(
  parameter [4:0] PART_ID     = 5'h0a,                                   // Arbitrary value.
  parameter       PAT_CYCLES  = `PATTERN_TIME_MS * (`CLK_FREQ_HZ / 1000)  // Stream pattern hold cycles.
) (
  input  wire        core_clk,               // System clock, 20 MHz.
  input  wire        rst,                    // Synchronous reset, active high.
  input  wire        frame_stb,              // Whole control frame present.
  input  wire [15:0] frame_data,             // Frame: direction, register number, data.
  input  wire        inz_mute_en_in,         // Infinite-zero mute enable from its own register.
  input  wire        frame_clock,            // Frame clock pulse per PCM sample.
  input  wire        word_clock,             // Word clock pulse per external-filter sample.
  input  wire        left_zero,              // Left sample is zero.
  input  wire        right_zero,             // Right sample is zero.
  input  wire        stream_byte_stb,        // Eight stream bits collected.
  input  wire [7:0]  left_stream_byte,       // Left stream byte.
  input  wire [7:0]  right_stream_byte,      // Right stream byte.
  output reg         rd_valid,               // Readback data valid, one cycle.
  output reg  [7:0]  rd_data,                // Readback data.
  output reg         soft_system_reset,      // One-cycle system reset pulse.
  output reg         stream_mode,            // 1-bit stream input selected.
  output reg         filter_bypass_en,       // External filter feeds modulator.
  output reg         mono_mode,              // Balanced mono operation.
  output reg         mono_channel_select,    // Mono source: 0 left, 1 right.
  output reg  [1:0]  modulator_rate_sel,     // Rate or stream bit clock speed.
  output reg         left_zero_flag_out,     // Gated left zero flag.
  output reg         right_zero_flag_out,    // Gated right zero flag.
  output reg         bipolar_zero_mute       // Hold outputs at bipolar zero level.
);

  // =====================================================================
  // Register state.
  reg  [1:0] stream_zero_flag_sel;           // Stream zero detection select.
  reg        pcm_zero_flag_en;               // PCM and filter-mode zero flag enable.
  wire [1:0] channel_zero_flag;              // Raw per-channel detector outputs.
  wire       is_write;                       // Frame is a write.
  wire [6:0] reg_num;                        // Addressed register.
  wire [7:0] wdata;                          // Write data.
  wire       sample_stb;                     // Strobe for the active PCM-side clock.
  wire [7:0] sys_mode_rd;                    // System mode readback.
  wire [7:0] ze_rd;                          // Zero enable readback.
  wire       right_zero_flag;                // Right status bit.
  wire       left_zero_flag;                 // Left status bit.

  assign is_write  = (frame_data[`FRAME_DIR_BIT] != `FRAME_DIR_READ);
  assign reg_num   = frame_data[14:8];
  assign wdata     = frame_data[7:0];
  assign sample_stb = filter_bypass_en ? word_clock : frame_clock;

  // Status bits follow the enable of the active mode.
  assign left_zero_flag  = channel_zero_flag[0] & (stream_mode ? (stream_zero_flag_sel != 2'h0) : pcm_zero_flag_en);
  assign right_zero_flag = channel_zero_flag[1] & (stream_mode ? (stream_zero_flag_sel != 2'h0) : pcm_zero_flag_en);

  // Reserved bits read as zero; the reset bit is write only.
  assign sys_mode_rd = {2'h0, stream_mode, filter_bypass_en, mono_mode,
                        mono_channel_select, modulator_rate_sel};
  assign ze_rd       = {5'h00, stream_zero_flag_sel, pcm_zero_flag_en};

  // =====================================================================
  // Per-channel detectors.
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1)
    begin : g_det
      chan_zero_detect #(
        .RUN_COUNT  (`ZERO_RUN_COUNT),
        .PAT_CYCLES (PAT_CYCLES)
      ) u_det (
        .core_clk    (core_clk),
        .rst         (rst | soft_system_reset),
        .sample_stb  (sample_stb),
        .sample_zero (ch == 0 ? left_zero : right_zero),
        .byte_stb    (stream_byte_stb),
        .stream_byte (ch == 0 ? left_stream_byte : right_stream_byte),
        .stream_mode (stream_mode),
        .stream_sel  (stream_zero_flag_sel),
        .zero_q      (channel_zero_flag[ch])
      );
    end
  endgenerate

  // =====================================================================
  // Register writes; a soft reset pulse returns fields to reset values.
  always @(posedge core_clk)
  begin
    if (rst || soft_system_reset)
    begin
      soft_system_reset    <= 1'b0;
      stream_mode          <= 1'b0;
      filter_bypass_en     <= 1'b0;
      mono_mode            <= 1'b0;
      mono_channel_select  <= 1'b0;
      modulator_rate_sel   <= `RATE_64X;
      stream_zero_flag_sel <= 2'h0;
      pcm_zero_flag_en     <= 1'b1;
    end
    else
    begin
      soft_system_reset <= 1'b0;
      if (frame_stb && is_write)
      begin
        case (reg_num)
          `REG_SYS_MODE:
          begin
            soft_system_reset   <= wdata[`SM_SOFT_SYSTEM_RESET_BIT];
            stream_mode         <= wdata[`SM_STREAM_BIT];
            filter_bypass_en    <= wdata[`SM_BYPASS_BIT];
            mono_mode           <= wdata[`SM_MONO_BIT];
            mono_channel_select <= wdata[`SM_MONO_CHANNEL_SELECT_BIT];
            // The reserved code keeps the current rate.
            if (wdata[`SM_RATE_HI:`SM_RATE_LO] != `RATE_RSV)
              modulator_rate_sel <= wdata[`SM_RATE_HI:`SM_RATE_LO];
          end
          `REG_ZF_ENABLE:
          begin
            stream_zero_flag_sel <= wdata[`ZE_DZ_HI:`ZE_DZ_LO];
            pcm_zero_flag_en     <= wdata[`ZE_PCM_ZERO_FLAG_EN_BIT];
          end
          // Status and ID registers ignore writes.
          default:
            pcm_zero_flag_en <= pcm_zero_flag_en;
        endcase
      end
    end
  end

  // =====================================================================
  // Readback: one cycle after a read frame.
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      rd_valid <= 1'b0;
      rd_data  <= 8'h00;
    end
    else
    begin
      rd_valid <= frame_stb && !is_write;
      if (frame_stb && !is_write)
      begin
        case (reg_num)
          `REG_SYS_MODE:  rd_data <= sys_mode_rd;
          `REG_ZF_ENABLE: rd_data <= ze_rd;
          `REG_ZF_STATUS: rd_data <= {6'h00, right_zero_flag, left_zero_flag};
          `REG_DEV_ID:    rd_data <= {3'h0, PART_ID};
          default:        rd_data <= 8'h00;
        endcase
      end
    end
  end

  // =====================================================================
  // Zero flag outputs and infinite-zero mute.
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      left_zero_flag_out  <= 1'b0;
      right_zero_flag_out <= 1'b0;
      bipolar_zero_mute   <= 1'b0;
    end
    else
    begin
      left_zero_flag_out  <= left_zero_flag;
      right_zero_flag_out <= right_zero_flag;
      // Mute needs both raw PCM runs complete and never applies in stream mode.
      bipolar_zero_mute   <= inz_mute_en_in && !stream_mode
                             && channel_zero_flag[0] && channel_zero_flag[1];
    end
  end

endmodule // dac_mode_ctrl_zero_detect

// ### bench/host_ctrl.sv
// Host model: sends whole control frames to the register bank.
// Assumes a frame is taken at the rising edge where frame_stb is high.
`timescale 1ns/100ps
module host_ctrl (
  input  wire        core_clk,   // System clock.
  output reg         frame_stb,  // Frame present.
  output reg  [15:0] frame_data  // Frame contents.
);
  initial
  begin
    frame_stb  = 1'b0;
    frame_data = 16'h0000;
  end
  // Present one frame for one cycle; reads always carry bit 15 set.
  task send(input [15:0] f);
  begin
    @(posedge core_clk);
    frame_stb  <= 1'b1;
    frame_data <= f;
    @(posedge core_clk);
    frame_stb  <= 1'b0;
    frame_data <= ~f; // Idle lines do not keep the last frame.
  end
  endtask
endmodule // host_ctrl

// ### bench/dac_mode_properties.sv
// Checker for the mode-control register bank.
// Assumes it is bound to the bank and sees only its ports.
`timescale 1ns/100ps
module dac_mode_properties #(
  parameter [4:0] PART_ID = 5'h0a  // Arbitrary value.
) (
  input wire        core_clk,
  input wire        rst,
  input wire        frame_stb,
  input wire [15:0] frame_data,
  input wire        inz_mute_en_in,
  input wire        frame_clock,
  input wire        left_zero,
  input wire        rd_valid,
  input wire [7:0]  rd_data,
  input wire        soft_system_reset,
  input wire        stream_mode,
  input wire        filter_bypass_en,
  input wire        mono_mode,
  input wire        mono_channel_select,
  input wire [1:0]  modulator_rate_sel,
  input wire        left_zero_flag_out,
  input wire        bipolar_zero_mute
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // A write frame to the system mode register.
  sequence s_sm_wr;
    frame_stb && !frame_data[15] && frame_data[14:8] == 7'h14;
  endsequence
  // A readback frame.
  sequence s_rd;
    frame_stb && frame_data[15];
  endsequence
  a_read_answer: assert property (s_rd |=> rd_valid)
    else $error("read frame gave no readback strobe");
  a_valid_cause: assert property (rd_valid |-> $past(frame_stb && frame_data[15]))
    else $error("readback strobe without a read frame");
  a_reset_pulse: assert property (s_sm_wr ##0 frame_data[6] |=> soft_system_reset ##1 !soft_system_reset)
    else $error("reset pulse not exactly one cycle");
  a_pulse_cause: assert property (soft_system_reset |-> $past(frame_stb && !frame_data[15]
    && frame_data[14:8] == 7'h14 && frame_data[6]))
    else $error("reset pulse without a reset write");
  a_mode_fields: assert property (s_sm_wr ##0 !frame_data[6] |=> stream_mode == $past(frame_data[5])
    && filter_bypass_en == $past(frame_data[4]) && mono_mode == $past(frame_data[3])
    && mono_channel_select == $past(frame_data[2]))
    else $error("mode bits not taken from write");
  a_rate_write: assert property (s_sm_wr ##0 (!frame_data[6] && frame_data[1:0] != 2'h3)
    |=> modulator_rate_sel == $past(frame_data[1:0]))
    else $error("rate field not taken from write");
  a_rate_rsv: assert property (s_sm_wr ##0 (frame_data[1:0] == 2'h3 && !frame_data[6])
    |=> $stable(modulator_rate_sel))
    else $error("reserved rate code changed the rate");
  a_mute_blocked: assert property ((!inz_mute_en_in || stream_mode) [*3] |-> !bipolar_zero_mute)
    else $error("mute while disabled or in stream mode");
  a_flag_clear: assert property (frame_clock && !left_zero && !stream_mode && !filter_bypass_en
    |-> ##[1:3] !left_zero_flag_out)
    else $error("left flag kept after nonzero sample");
  a_id_read: assert property (s_rd ##0 frame_data[14:8] == 7'h17 |=> rd_data == {3'h0, PART_ID})
    else $error("identifier readback wrong");
endmodule // dac_mode_properties

bind dac_mode_ctrl_zero_detect dac_mode_properties #(.PART_ID(PART_ID)) u_props (
  .core_clk(core_clk), .rst(rst), .frame_stb(frame_stb), .frame_data(frame_data),
  .inz_mute_en_in(inz_mute_en_in), .frame_clock(frame_clock), .left_zero(left_zero),
  .rd_valid(rd_valid), .rd_data(rd_data), .soft_system_reset(soft_system_reset),
  .stream_mode(stream_mode), .filter_bypass_en(filter_bypass_en), .mono_mode(mono_mode),
  .mono_channel_select(mono_channel_select), .modulator_rate_sel(modulator_rate_sel),
  .left_zero_flag_out(left_zero_flag_out), .bipolar_zero_mute(bipolar_zero_mute));

// ### bench/tb_top.sv
// Testbench for the mode-control register bank.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/100ps
module tb_top;
  localparam [4:0] ID  = 5'h15;  // Arbitrary identifier value.
  localparam       PAT = 50;     // Short pattern hold.
  reg        core_clk = 1'b0;
  reg        rst = 1'b1;
  reg        inz_mute_en_in = 1'b0;
  reg        frame_clock = 1'b0;
  reg        word_clock = 1'b0;
  reg        left_zero = 1'b0;
  reg        right_zero = 1'b0;
  reg        stream_byte_stb = 1'b0;
  reg  [7:0] left_stream_byte = 8'h00;
  reg  [7:0] right_stream_byte = 8'h00;
  wire       frame_stb, rd_valid, soft_system_reset, stream_mode, filter_bypass_en;
  wire       mono_mode, mono_channel_select, left_zero_flag_out, right_zero_flag_out, bipolar_zero_mute;
  wire [15:0] frame_data;
  wire [7:0] rd_data;
  wire [1:0] modulator_rate_sel;
  wire [7:0] mode_bits = {2'h0, stream_mode, filter_bypass_en, mono_mode, mono_channel_select,
                          modulator_rate_sel};
  wire [7:0] flags = {6'h0, right_zero_flag_out, left_zero_flag_out};
  integer    error_cnt = 0;
  integer    cmp_count = 0;
  integer    cyc = 0;
  host_ctrl host (.core_clk(core_clk), .frame_stb(frame_stb), .frame_data(frame_data));
  dac_mode_ctrl_zero_detect #(.PART_ID(ID), .PAT_CYCLES(PAT)) uut (
    .core_clk(core_clk), .rst(rst), .frame_stb(frame_stb), .frame_data(frame_data),
    .inz_mute_en_in(inz_mute_en_in), .frame_clock(frame_clock), .word_clock(word_clock),
    .left_zero(left_zero), .right_zero(right_zero), .stream_byte_stb(stream_byte_stb),
    .left_stream_byte(left_stream_byte), .right_stream_byte(right_stream_byte),
    .rd_valid(rd_valid), .rd_data(rd_data), .soft_system_reset(soft_system_reset),
    .stream_mode(stream_mode), .filter_bypass_en(filter_bypass_en), .mono_mode(mono_mode),
    .mono_channel_select(mono_channel_select), .modulator_rate_sel(modulator_rate_sel),
    .left_zero_flag_out(left_zero_flag_out), .right_zero_flag_out(right_zero_flag_out),
    .bipolar_zero_mute(bipolar_zero_mute));
  always #25 core_clk = ~core_clk;
  // Cut a hang short.
  always @(posedge core_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt = error_cnt + 1;
      close_out;
    end
  end
  task close_out;
  begin
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
  begin
    cmp_count = cmp_count + 1;
    if (got !== exp)
      begin
        error_cnt = error_cnt + 1;
        $display("ERROR %0t got %h want %h", $time, got, exp);
      end
  end
  endtask
  task rd(input [6:0] r, input [7:0] exp);
  begin
    host.send({1'b1, r, 8'h00});
    #1;
    chk({7'h0, rd_valid}, 8'h01);
    chk(rd_data, exp);
  end
  endtask
  task wr(input [6:0] r, input [7:0] d);
  begin
    host.send({1'b0, r, d});
    #1;
  end
  endtask
  // Sample strobes on the frame clock or word clock with given zero levels.
  task pulses(input integer n, input wc, input lz, input rz);
  begin
    repeat (n)
    begin
      @(posedge core_clk);
      frame_clock <= !wc;
      word_clock  <= wc;
      left_zero   <= lz;
      right_zero  <= rz;
      @(posedge core_clk);
      frame_clock <= 1'b0;
      word_clock  <= 1'b0;
    end
    repeat (4) @(posedge core_clk);
    #1;
  end
  endtask
  task bytes(input integer n, input [7:0] l, input [7:0] r);
  begin
    repeat (n)
    begin
      @(posedge core_clk);
      stream_byte_stb   <= 1'b1;
      left_stream_byte  <= l;
      right_stream_byte <= r;
    end
    @(posedge core_clk);
    stream_byte_stb <= 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
  end
  endtask
  task t_regs;
  begin
    rd(7'h14, 8'h00);
    rd(7'h15, 8'h01);
    wr(7'h16, 8'hff);
    wr(7'h17, 8'hff);
    rd(7'h16, 8'h00);
    rd(7'h17, {3'h0, ID});
  end
  endtask
  task t_mode;
  begin
    wr(7'h14, 8'h9e);
    chk(mode_bits, 8'h1e);
    rd(7'h14, 8'h1e);
    wr(7'h14, 8'h0b);
    chk(mode_bits, 8'h0a);
    wr(7'h14, 8'h01);
    chk(mode_bits, 8'h01);
  end
  endtask
  task t_soft_reset;
  begin
    wr(7'h14, 8'h5e);
    chk({7'h0, soft_system_reset}, 8'h01);
    @(posedge core_clk);
    #1;
    chk({7'h0, soft_system_reset}, 8'h00);
    chk(mode_bits, 8'h00);
  end
  endtask
  task t_pcm(input wc);
  begin
    wr(7'h14, {3'h0, wc, 4'h0});
    inz_mute_en_in <= 1'b1;
    pulses(1, wc, 0, 0);
    pulses(1023, wc, 1, 1);
    chk(flags, 8'h00);
    chk({7'h0, bipolar_zero_mute}, 8'h00);
    pulses(1, wc, 1, 1);
    chk(flags, 8'h03);
    chk({7'h0, bipolar_zero_mute}, 8'h01);
    pulses(1, wc, 0, 1);
    rd(7'h16, 8'h02);
    wr(7'h15, 8'h00);
    @(posedge core_clk);
    #1;
    chk(flags, 8'h00);
    wr(7'h15, 8'h01);
  end
  endtask
  task t_stream;
  begin
    wr(7'h14, 8'h22);
    chk(mode_bits, 8'h22);
    wr(7'h15, 8'h02);
    bytes(2, 8'h0f, 8'h01);
    chk(flags, 8'h01);
    bytes(2, 8'h3c, 8'h5a);
    chk({7'h0, bipolar_zero_mute}, 8'h00);
    wr(7'h15, 8'h06);
    bytes(10, 8'h96, 8'h3c);
    chk(flags, 8'h00);
    bytes(PAT, 8'h96, 8'h3c);
    chk(flags, 8'h01);
    wr(7'h15, 8'h00);
    bytes(1, 8'h96, 8'h3c);
    chk(flags, 8'h00);
  end
  endtask
  initial
  begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    t_regs;
    t_mode;
    t_soft_reset;
    t_pcm(1'b0);
    t_pcm(1'b1);
    t_stream;
    close_out;
  end
endmodule // tb_top
